// file: i2c_rx_guard_pkg.sv
// constants shared by the receive-buffer overflow guard and its fifo
//
// Behaviour
// - set buffer-written flag on each byte push to the fifo
// - flag marks unread byte, next byte stalls
// - receive buffer read clears the written flag
// - read colliding with set: flag stays, stall
// - readable status shows SCL held low
package i2c_rx_guard_pkg;

   // ==========================================================
   // data path shape
   localparam int          DATA_W      = 8;    // one received byte
   localparam int          FIFO_DEPTH  = 32;   // bytes buffered toward the core
   localparam logic [3:0]  BITS_BYTE   = 4'h8; // data bits before the ack slot

   // ==========================================================
   // timing figures
   localparam int          MCLK_NS       = 100; // main clock period
   localparam int          SCL_MIN_MCLK  = 4;   // double read safe above this ratio
   localparam int          STALL_BITCLKS = 3;   // low time software waits for

   // ==========================================================
   // reset values of the pin drivers
   localparam logic        SCL_DRV_RST = 1'b0; // open drain: drive value is low
   localparam logic        SDA_DRV_RST = 1'b0;
   localparam logic        OE_RST      = 1'b0; // pins released in reset

   // ==========================================================
   // receiver states
   typedef enum logic [1:0] {
      ST_IDLE,   // waiting for a start condition
      ST_BITS,   // shifting data bits
      ST_STALL,  // byte done but buffer unread: hold SCL low
      ST_ACK     // driving the acknowledge bit
   } rx_state_t;

endpackage : i2c_rx_guard_pkg

// file: rx_byte_fifo.sv
// byte fifo between the bus receiver and the receive buffer read port
`timescale 1ns/100ps
module rx_byte_fifo #(
   parameter int WIDTH = i2c_rx_guard_pkg::DATA_W,
   parameter int DEPTH = i2c_rx_guard_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side, data held in a register
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // storage and pointers
   logic [WIDTH-1:0] mem [DEPTH];   // array, no reset needed
   logic [AW-1:0]    wr_ptr;        // next slot to write
   logic [AW-1:0]    rd_ptr;        // next slot to read
   logic [AW:0]      count;         // words held in the array
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic             push;          // word accepted this cycle
   logic             pop;           // word moved into the output register

   // ==========================================================
   // next values
   always_comb begin
      in_ready       = (count != (AW+1)'(DEPTH));   // honest full
      push           = in_valid && in_ready;
      // refill output register when empty or being drained
      pop            = (count != '0) && (!out_valid || out_ready);
      next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
      next_out_data  = pop ? mem[rd_ptr] : out_data;
      if (pop) begin
         next_out_valid = 1'b1;
      end else if (out_ready) begin
         next_out_valid = 1'b0;               // drained, nothing behind it
      end else begin
         next_out_valid = out_valid;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         out_valid <= next_out_valid;
         out_data  <= next_out_data;
      end
   end

   // write port kept apart so the array carries no reset
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule : rx_byte_fifo

// file: i2c_rx_guard.sv
// i2c byte receiver with buffer-written tracking and overflow stall
`timescale 1ns/100ps
module i2c_rx_guard #(
   parameter int DEPTH = i2c_rx_guard_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                                 MCLK,
   input  wire logic                                 RST_N,
   // i2c clock pin, open drain
   input  wire logic                                 SCL_IN,
   output logic                                      SCL_OUT,
   output logic                                      SCL_OE,
   // i2c data pin, open drain
   input  wire logic                                 SDA_IN,
   output logic                                      SDA_OUT,
   output logic                                      SDA_OE,
   // receive buffer read port
   input  wire logic                                 RX_RD,
   output logic [i2c_rx_guard_pkg::DATA_W-1:0]       RX_DATA,
   output logic                                      RX_VALID,
   // status
   output logic                                      RX_WRITTEN,
   output logic                                      RX_STALL,
   output logic                                      SCL_HELD_LOW
);

   // ==========================================================
   // pin synchronisers: first stage feeds only the second
   logic scl_meta;     // first stage, SCL
   logic scl_sync;     // second stage, SCL
   logic scl_prev;     // delayed copy for edge finding
   logic sda_meta;     // first stage, SDA
   logic sda_sync;     // second stage, SDA
   logic sda_prev;     // delayed copy for start and stop

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         scl_meta <= 1'b1;   // idle bus reads high
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_meta <= SCL_IN;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= SDA_IN;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   // ==========================================================
   // bus events in the MCLK domain
   logic scl_rise;     // sample point for data bits
   logic scl_fall;     // end of each bit slot
   logic bus_start;    // SDA falls while SCL high
   logic bus_stop;     // SDA rises while SCL high

   always_comb begin
      scl_rise  = scl_sync && !scl_prev;
      scl_fall  = !scl_sync && scl_prev;
      bus_start = scl_sync && scl_prev && !sda_sync && sda_prev;
      bus_stop  = scl_sync && scl_prev && sda_sync && !sda_prev;
   end

   // ==========================================================
   // receiver state
   i2c_rx_guard_pkg::rx_state_t state;        // receiver phase
   i2c_rx_guard_pkg::rx_state_t next_state;
   logic [3:0]                  bit_cnt;      // data bits taken so far
   logic [3:0]                  next_bit_cnt;
   logic [7:0]                  shift;        // incoming byte, msb first
   logic [7:0]                  next_shift;
   logic                        written;      // receive buffer holds unread byte
   logic                        next_written;
   logic                        next_scl_oe;
   logic                        next_sda_oe;
   logic                        push;         // byte handed to the fifo
   logic                        fifo_ready;   // fifo can take a byte
   logic                        blocked;      // overflow risk on byte end

   // ==========================================================
   // next values of the receiver
   always_comb begin
      next_state   = state;
      next_bit_cnt = bit_cnt;
      next_shift   = shift;
      next_scl_oe  = SCL_OE;
      next_sda_oe  = SDA_OE;
      push         = 1'b0;
      // unread byte or full fifo means the next byte would be lost
      blocked      = written || !fifo_ready;
      case (state)
         // waiting for a start condition
         i2c_rx_guard_pkg::ST_IDLE: begin
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
         end
         // shift bits on rising SCL, close the byte on the falling edge
         i2c_rx_guard_pkg::ST_BITS: begin
            if (scl_rise && bit_cnt != i2c_rx_guard_pkg::BITS_BYTE) begin
               next_shift   = {shift[6:0], sda_sync};
               next_bit_cnt = bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == i2c_rx_guard_pkg::BITS_BYTE) begin
               if (blocked) begin
                  // hold the clock low until the core catches up
                  next_scl_oe = 1'b1;
                  next_state  = i2c_rx_guard_pkg::ST_STALL;
               end else begin
                  push        = 1'b1;
                  next_sda_oe = 1'b1;   // acknowledge the byte
                  next_state  = i2c_rx_guard_pkg::ST_ACK;
               end
            end
         end
         // stalled: a lost clear keeps us here until another read
         i2c_rx_guard_pkg::ST_STALL: begin
            next_scl_oe = 1'b1;
            if (!blocked) begin
               push        = 1'b1;
               next_scl_oe = 1'b0;
               next_sda_oe = 1'b1;
               next_state  = i2c_rx_guard_pkg::ST_ACK;
            end
         end
         // ack slot ends on the next falling SCL edge
         i2c_rx_guard_pkg::ST_ACK: begin
            if (scl_fall) begin
               next_sda_oe  = 1'b0;
               next_bit_cnt = 4'h0;
               next_state   = i2c_rx_guard_pkg::ST_BITS;
            end
         end
         default: begin
            next_state  = i2c_rx_guard_pkg::ST_IDLE;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
         end
      endcase
      // start and stop override any phase; a stop also drops a stall
      if (bus_start) begin
         next_state   = i2c_rx_guard_pkg::ST_BITS;
         next_bit_cnt = 4'h0;
         next_sda_oe  = 1'b0;
         next_scl_oe  = 1'b0;
      end else if (bus_stop) begin
         next_state  = i2c_rx_guard_pkg::ST_IDLE;
         next_sda_oe = 1'b0;
         next_scl_oe = 1'b0;
      end
   end

   // ==========================================================
   // written flag: setting wins when a read lands in the same cycle,
   // which is exactly how a clear gets lost and a later stall follows
   always_comb begin
      if (push) begin
         next_written = 1'b1;
      end else if (RX_RD) begin
         next_written = 1'b0;
      end else begin
         next_written = written;
      end
   end

   // ==========================================================
   // receiver and pin registers
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         state        <= i2c_rx_guard_pkg::ST_IDLE;
         bit_cnt      <= 4'h0;
         shift        <= 8'h00;
         written      <= 1'b0;
         SCL_OE       <= i2c_rx_guard_pkg::OE_RST;
         SDA_OE       <= i2c_rx_guard_pkg::OE_RST;
         SCL_OUT      <= i2c_rx_guard_pkg::SCL_DRV_RST;
         SDA_OUT      <= i2c_rx_guard_pkg::SDA_DRV_RST;
         RX_WRITTEN   <= 1'b0;
         RX_STALL     <= 1'b0;
         SCL_HELD_LOW <= 1'b0;
      end else begin
         state        <= next_state;
         bit_cnt      <= next_bit_cnt;
         shift        <= next_shift;
         written      <= next_written;
         SCL_OE       <= next_scl_oe;
         SDA_OE       <= next_sda_oe;
         SCL_OUT      <= i2c_rx_guard_pkg::SCL_DRV_RST;   // open drain only pulls low
         SDA_OUT      <= i2c_rx_guard_pkg::SDA_DRV_RST;
         RX_WRITTEN   <= next_written;
         RX_STALL     <= (next_state == i2c_rx_guard_pkg::ST_STALL);
         // line low as seen after sync, whoever pulls it
         SCL_HELD_LOW <= !scl_sync;
      end
   end

   // ==========================================================
   // byte buffer; its output register is the receive buffer
   rx_byte_fifo #(
      .WIDTH (i2c_rx_guard_pkg::DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (MCLK),
      .rst_n     (RST_N),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (shift),
      .out_valid (RX_VALID),
      .out_ready (RX_RD),
      .out_data  (RX_DATA)
   );

endmodule : i2c_rx_guard

// file: i2c_master_model.sv
// bus master model: sends bytes msb first and waits out clock stretching
`timescale 1ns/100ps
module i2c_master_model (
   // resolved wire levels
   input  wire logic scl,
   input  wire logic sda,
   // pull-down enables, high pulls the wire low
   output logic      scl_low,
   output logic      sda_low,
   // level seen in the last acknowledge slot
   output logic      ack
);
   localparam int HALF_NS = 400; // half of the 800 ns link period
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      ack     = 1'b1;
   end
   // release scl, then wait while the device stretches it (bounded)
   task automatic rise();
      int n;
      n = 0;
      scl_low = 1'b0;
      while (scl !== 1'b1 && n < 4000) begin
         #100;
         n++;
      end
      #HALF_NS;
   endtask : rise
   // start: data falls while the clock is high
   task automatic start();
      sda_low = 1'b1;
      #HALF_NS;
      scl_low = 1'b1;
      #200;
   endtask : start
   // eight data bits, then a released data line for the ack slot
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~b[i];
         #200;
         rise();
         scl_low = 1'b1;
         #200;
      end
      sda_low = 1'b0;
      #200;
      rise();
      ack = sda;
      scl_low = 1'b1;
      #200;
   endtask : send
   // stop: data rises while the clock is high
   task automatic stop();
      sda_low = 1'b1;
      #200;
      rise();
      sda_low = 1'b0;
      #HALF_NS;
   endtask : stop
endmodule : i2c_master_model

// file: i2c_rx_guard_sva.sv
// pin-level assertions for the receive overflow guard
`timescale 1ns/100ps
module i2c_rx_guard_sva #(
   parameter int DEPTH = 32
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic SCL_IN,
   input wire logic SCL_OUT,
   input wire logic SCL_OE,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic RX_RD,
   input wire logic RX_WRITTEN,
   input wire logic RX_STALL,
   input wire logic SCL_HELD_LOW
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // ==========================================
   // stall, acknowledge and written flag
   chk_stall_is_oe: assert property (RX_STALL == SCL_OE)
      else $error("stall flag and scl drive differ");
   chk_drive_low: assert property (!SCL_OUT && !SDA_OUT)
      else $error("open drain pin driven high");
   chk_read_clears: assert property (RX_RD |=> !RX_WRITTEN || $rose(SDA_OE))
      else $error("read did not clear written flag");
   chk_ack_sets_flag: assert property ($rose(SDA_OE) |-> RX_WRITTEN)
      else $error("byte taken without written flag");
   chk_stall_needs_flag: assert property ($rose(SCL_OE) |-> $past(RX_WRITTEN))
      else $error("stall without unread byte");
   chk_stall_to_ack: assert property ($fell(SCL_OE) |-> SDA_OE && RX_WRITTEN)
      else $error("stall left without taking byte");
   chk_ack_or_stall: assert property (!(SDA_OE && SCL_OE))
      else $error("ack and stall at once");
   // ==========================================
   // clock low status follows the wire
   chk_low_seen: assert property (!SCL_IN [*6] |-> SCL_HELD_LOW)
      else $error("low scl not shown");
   chk_high_seen: assert property (SCL_IN [*6] |-> !SCL_HELD_LOW)
      else $error("high scl shown as low");
   cover property (RX_STALL ##1 !RX_STALL);
   cover property (RX_RD ##1 RX_RD);
   cover property ($rose(SDA_OE));
   cover property (RX_RD ##1 ($rose(SDA_OE) && RX_WRITTEN));
endmodule : i2c_rx_guard_sva
bind i2c_rx_guard i2c_rx_guard_sva #(.DEPTH(DEPTH)) u_sva (.MCLK(MCLK), .RST_N(RST_N),
   .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT),
   .SDA_OE(SDA_OE), .RX_RD(RX_RD), .RX_WRITTEN(RX_WRITTEN), .RX_STALL(RX_STALL),
   .SCL_HELD_LOW(SCL_HELD_LOW));

// file: testbench.sv
// self-checking bench: bytes in over the bus, out through the read port
`timescale 1ns/100ps
module testbench;
   logic       MCLK, RST_N, RX_RD, m_scl, m_sda, ack, stall_seen;
   logic       SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, RX_VALID, RX_WRITTEN, RX_STALL, SCL_HELD_LOW;
   logic [7:0] RX_DATA;
   logic [7:0] exp_q[$];   // bytes sent, oldest first
   int         failures, n_compared;
   wire        scl = ~(SCL_OE | m_scl); // open drain with pull-up
   wire        sda = ~(SDA_OE | m_sda);
   i2c_rx_guard u_dut (.MCLK(MCLK), .RST_N(RST_N), .SCL_IN(scl), .SCL_OUT(SCL_OUT),
      .SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .RX_RD(RX_RD),
      .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_WRITTEN(RX_WRITTEN),
      .RX_STALL(RX_STALL), .SCL_HELD_LOW(SCL_HELD_LOW));
   i2c_master_model u_master (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda),
      .ack(ack));
   always #50 MCLK = ~MCLK;
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte
   task automatic test_done();
      if (failures == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   // n back-to-back read pulses
   task automatic rd(input int n);
      @(posedge MCLK);
      #1 RX_RD = 1'b1;
      repeat (n) @(posedge MCLK);
      #1 RX_RD = 1'b0;
   endtask : rd
   // send one byte and expect it acknowledged
   task automatic put(input logic [7:0] b);
      exp_q.push_back(b);
      u_master.send(b);
      chk_bit("ack", 1'b0, ack);
   endtask : put
   // byte sent into a stall: wait three bit clocks of low, then read
   task automatic stall_put();
      stall_seen = 1'b0;
      fork
         put(8'($urandom));
         begin
            for (int n = 0; n < 2000 && RX_STALL !== 1'b1; n++) @(negedge MCLK);
            repeat (24) @(negedge MCLK);
            chk_bit("held_low", 1'b1, SCL_HELD_LOW);
            chk_bit("stall", 1'b1, RX_STALL);
            rd(1);
         end
      join
      chk_bit("stall_seen", 1'b1, stall_seen);
   endtask : stall_put
   // monitor: a read takes the oldest byte sent
   always @(negedge MCLK) begin
      if (RX_RD === 1'b1 && RX_VALID === 1'b1) begin
         chk_byte("rx_data", exp_q.size() ? exp_q.pop_front() : 8'hXX, RX_DATA);
      end
      if (RX_STALL === 1'b1) stall_seen = 1'b1;
   end
   initial begin
      repeat (20000) @(posedge MCLK);
      failures++;
      test_done();
   end
   initial begin
      MCLK = 1'b0;
      RST_N = 1'b0;
      RX_RD = 1'b0;
      failures = 0;
      n_compared = 0;
      void'($urandom(32'h5309));
      repeat (16) @(posedge MCLK);
      #1 RST_N = 1'b1;
      repeat (4) @(posedge MCLK);
      // master runs on the same small offset as every other input
      #1 u_master.start();
      put(8'($urandom));
      for (int k = 0; k < 8; k++) begin
         stall_seen = 1'b0;
         if (!k[0]) begin
            // double read first, so the next byte must not stall
            rd(2);
            chk_bit("written", 1'b0, RX_WRITTEN);
            put(8'($urandom));
            chk_bit("stall_seen", 1'b0, stall_seen);
         end else begin
            // leave the byte unread: bus stalls, wait 3 bit clocks, then read
            stall_put();
         end
      end
      // a single read landing on the byte-end push loses its clear
      rd(2);
      fork
         put(8'($urandom));
         begin
            repeat (8) @(posedge scl);
            @(negedge scl);
            @(posedge MCLK);
            rd(1);
         end
      join
      chk_bit("lost_clear", 1'b1, RX_WRITTEN);
      // so the following byte stalls although a read was made
      stall_put();
      u_master.stop();
      rd(1);
      chk_bit("valid", 1'b0, RX_VALID);
      chk_bit("drained", 1'b1, exp_q.size() == 0);
      test_done();
   end
endmodule : testbench
